// file: hw/gdr_params.svh
`ifndef GDR_PARAMS_SVH
`define GDR_PARAMS_SVH

// reply message identifiers, low six bits of a header
`define GDR_ID_ST0        6'h05
`define GDR_ID_ST1        6'h06
`define GDR_ID_SET2       6'h07
`define GDR_ID_GET2       6'h08
`define GDR_ACK_BIT       6
`define GDR_UNSOL_BIT     7

// status low bit positions
`define GDR_S0_TJ_WARN    0
`define GDR_S0_TJ_OVER    1
`define GDR_S0_VDD_UV     2
`define GDR_S0_VDDH_OV    3
`define GDR_S0_VDD_OV     4
`define GDR_S0_BUCK_OC    5
`define GDR_S0_BUCK_UVW   6
`define GDR_S0_BUCK_BOR   7

// status high bit positions
`define GDR_S1_EXT_UNDERVOLTAGE_LOCKOUT   2
`define GDR_S1_EXT_OC     3
`define GDR_S1_CFG_LOST   4
`define GDR_S1_LDO5_UNDERVOLTAGE_LOCKOUT  5
`define GDR_S1_RSVD_MASK  8'hC3

// reset values
`define GDR_S0_RESET      8'h01
`define GDR_S1_RESET      8'h10
`define GDR_CFG2_RESET    8'h00
`define GDR_CFG2_RSVD     8'hE0

// gate timing fields and times
`define GDR_DEAD_LSB      2
`define GDR_DEAD_MAX_NS   2000
`define GDR_DEAD_STEP_NS  250
`define GDR_BLANK_MAX_NS  4000
`define GDR_CLK_NS        100

`endif

// file: hw/gdr_pkg.sv
package gdr_pkg;

	typedef enum logic [1:0] {
		GDR_REQ_ST0,
		GDR_REQ_ST1,
		GDR_REQ_SET2,
		GDR_REQ_GET2
	} gdr_req_t;

	typedef enum logic [1:0] {
		GDR_IDLE,
		GDR_HEAD,
		GDR_DATA
	} gdr_state_t;

	// analog comparator levels, one per flag except config lost
	typedef struct packed {
		logic ldo5_undervoltage_lockout;
		logic ext_oc;
		logic ext_undervoltage_lockout;
		logic buck_bor;
		logic buck_uvw;
		logic buck_oc;
		logic vdd_ov;
		logic vddh_ov;
		logic vdd_uv;
		logic tj_over;
		logic tj_warn;
	} gdr_fault_t;

	typedef struct packed {
		logic [7:0] head;
		logic [7:0] data;
	} gdr_reply_t;

endpackage : gdr_pkg

// file: hw/gdr_reply.sv
// Functional notes
// (RULE1) status-low header: 05H nack, 45H ack, 85H unsolicited.
// (RULE2) status-high header: 06H nack, 46H ack, 86H unsolicited.
// (RULE3) status-low bit0 warns above 115C, bit1 overtemperature; warning resets set.
// (RULE4) status-low bits 2,3,4: supply undervoltage, driver overvoltage, supply overvoltage.
// (RULE5) status-low bits 5,6,7: regulator overcurrent, undervoltage warning, brown-out.
// (RULE6) status-high bit2 transistor lockout, bit3 transistor overcurrent.
// (RULE7) status-high bit4 marks configuration lost, set at start-up.
// (RULE8) status-high bit5 is 5V regulator lockout; bits 0,1,6,7 read zero.
// (RULE9) set-config reply header: 07H nack, 47H ack.
// (RULE10) get-config reply header: 08H nack, 48H ack, then configuration byte.
// (RULE11) config bits 4:2 pick dead time 2000ns minus 250ns per step.
// (RULE12) config bits 1:0 pick blanking 4us, 2us, 1us, 500ns.
// (RULE13) every reply is header byte then one data byte.
// (RULE14) header bit6 ack, bit7 unsolicited, low bits message type.
`timescale 1ns/1ns
`include "gdr_params.svh"

module gdr_reply #(
	parameter int CLK_PERIOD_NS = `GDR_CLK_NS
) (
	input  wire logic              core_clk_in,
	input  wire logic              rst_b_in,
	input  wire gdr_pkg::gdr_fault_t fault_in,
	input  wire logic              brownout_in,
	input  wire logic              req_valid_in,
	output logic                   req_ready_out,
	input  wire gdr_pkg::gdr_req_t req_kind_in,
	input  wire logic              req_ok_in,
	input  wire logic [7:0]        req_data_in,
	output logic                   tx_valid_out,
	input  wire logic              tx_ready_in,
	output logic [7:0]             tx_byte_out,
	output logic                   tx_last_out,
	output logic [7:0]             fault_status_low_out,
	output logic [7:0]             fault_status_high_out,
	output logic [7:0]             gate_timing_config_out,
	output logic [7:0]             dead_time_cycles_out,
	output logic [7:0]             blank_time_cycles_out
);

	// dead step must span a cycle, longest blanking must fit eight bits
	if (CLK_PERIOD_NS > `GDR_DEAD_STEP_NS
		|| CLK_PERIOD_NS * 255 < `GDR_BLANK_MAX_NS) begin : g_bad_period
		$error("clock period out of range");
	end

	function automatic logic [7:0] ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1)
			c = 1;
		if (c > 255)
			c = 255;
		return c[7:0];
	endfunction : ns_to_cycles

	function automatic logic [7:0] head_of(input logic [5:0] id, input logic ack,
		input logic unsol);
		logic [7:0] h;
		h = {2'b00, id};
		h[`GDR_ACK_BIT] = ack;
		h[`GDR_UNSOL_BIT] = unsol;
		return h;
	endfunction : head_of

	localparam logic [7:0] DEAD_RESET_CYCLES  = ns_to_cycles(`GDR_DEAD_MAX_NS);
	localparam logic [7:0] BLANK_RESET_CYCLES = ns_to_cycles(`GDR_BLANK_MAX_NS);

	gdr_pkg::gdr_fault_t fault_s1_reg;
	gdr_pkg::gdr_fault_t fault_s2_reg;
	logic                bor_s1_reg;
	logic                bor_s2_reg;
	logic [7:0]          st0_reg;
	logic [7:0]          st0_next;
	logic [7:0]          st1_reg;
	logic [7:0]          st1_next;
	logic [7:0]          cfg_reg;
	logic                pend0_reg;
	logic                pend1_reg;
	gdr_pkg::gdr_state_t state_reg;
	gdr_pkg::gdr_reply_t reply_reg;
	logic [7:0]          byte_reg;
	logic [7:0]          dead_reg;
	logic [7:0]          blank_reg;
	logic                take_req;
	logic                start_unsol;
	logic                set_ack;
	logic                head_done;
	logic                data_done;

	// two-stage pin synchronisers
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fault_s1_reg <= '0;
			fault_s2_reg <= '0;
			bor_s1_reg   <= 1'b0;
			bor_s2_reg   <= 1'b0;
		end else begin
			fault_s1_reg <= fault_in;
			fault_s2_reg <= fault_s1_reg;
			bor_s1_reg   <= brownout_in;
			bor_s2_reg   <= bor_s1_reg;
		end
	end

	assign req_ready_out = (state_reg == gdr_pkg::GDR_IDLE);
	assign take_req      = req_valid_in && req_ready_out;
	assign start_unsol   = req_ready_out && !req_valid_in && (pend0_reg || pend1_reg);
	assign set_ack       = take_req && req_ok_in && (req_kind_in == gdr_pkg::GDR_REQ_SET2)
		&& ((req_data_in & `GDR_CFG2_RSVD) == 8'h00);
	assign head_done     = (state_reg == gdr_pkg::GDR_HEAD) && tx_ready_in;
	assign data_done     = (state_reg == gdr_pkg::GDR_DATA) && tx_ready_in;

	always_comb begin
		st0_next = 8'h00;
		st0_next[`GDR_S0_TJ_WARN]  = fault_s2_reg.tj_warn; // RULE3
		st0_next[`GDR_S0_TJ_OVER]  = fault_s2_reg.tj_over; // RULE3
		st0_next[`GDR_S0_VDD_UV]   = fault_s2_reg.vdd_uv; // RULE4
		st0_next[`GDR_S0_VDDH_OV]  = fault_s2_reg.vddh_ov; // RULE4
		st0_next[`GDR_S0_VDD_OV]   = fault_s2_reg.vdd_ov; // RULE4
		st0_next[`GDR_S0_BUCK_OC]  = fault_s2_reg.buck_oc; // RULE5
		st0_next[`GDR_S0_BUCK_UVW] = fault_s2_reg.buck_uvw; // RULE5
		st0_next[`GDR_S0_BUCK_BOR] = fault_s2_reg.buck_bor; // RULE5
	end

	always_comb begin
		st1_next = 8'h00; // RULE8
		st1_next[`GDR_S1_EXT_UNDERVOLTAGE_LOCKOUT]  = fault_s2_reg.ext_undervoltage_lockout; // RULE6
		st1_next[`GDR_S1_EXT_OC]    = fault_s2_reg.ext_oc; // RULE6
		st1_next[`GDR_S1_LDO5_UNDERVOLTAGE_LOCKOUT] = fault_s2_reg.ldo5_undervoltage_lockout; // RULE8
		// lost flag: a brown-out sets it, a good config write clears it
		st1_next[`GDR_S1_CFG_LOST]  = bor_s2_reg
			|| (st1_reg[`GDR_S1_CFG_LOST] && !set_ack); // RULE7
	end

	// warning flag comes out of reset set
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			st0_reg <= `GDR_S0_RESET; // RULE3
		else
			st0_reg <= st0_next;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			st1_reg <= `GDR_S1_RESET; // RULE7
		else
			st1_reg <= st1_next;
	end

	// brown-out returns the timing to default
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			cfg_reg <= `GDR_CFG2_RESET;
		else if (bor_s2_reg)
			cfg_reg <= `GDR_CFG2_RESET;
		else if (set_ack)
			cfg_reg <= req_data_in; // RULE9
	end

	// timing counts rounded up to whole cycles
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dead_reg  <= DEAD_RESET_CYCLES;
			blank_reg <= BLANK_RESET_CYCLES;
		end else begin
			dead_reg  <= ns_to_cycles(`GDR_DEAD_MAX_NS - `GDR_DEAD_STEP_NS
				* int'(cfg_reg[`GDR_DEAD_LSB +: 3])); // RULE11
			blank_reg <= ns_to_cycles(`GDR_BLANK_MAX_NS >> cfg_reg[1:0]); // RULE12
		end
	end

	// a newly raised flag queues an unsolicited report; set beats clear
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend0_reg <= 1'b0;
			pend1_reg <= 1'b0;
		end else begin
			pend0_reg <= (|(st0_next & ~st0_reg))
				|| (pend0_reg && !(start_unsol && pend0_reg));
			pend1_reg <= (|(st1_next & ~st1_reg))
				|| (pend1_reg && !(start_unsol && !pend0_reg));
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			state_reg <= gdr_pkg::GDR_IDLE;
		else begin
			unique case (state_reg)
				gdr_pkg::GDR_IDLE: begin
					if (take_req || start_unsol)
						state_reg <= gdr_pkg::GDR_HEAD;
				end
				gdr_pkg::GDR_HEAD: begin
					if (head_done)
						state_reg <= gdr_pkg::GDR_DATA; // RULE13
				end
				gdr_pkg::GDR_DATA: begin
					if (data_done)
						state_reg <= gdr_pkg::GDR_IDLE;
				end
				default: state_reg <= gdr_pkg::GDR_IDLE;
			endcase
		end
	end

	// snapshot header and data when a reply starts
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			reply_reg <= '0;
		else if (take_req) begin
			unique case (req_kind_in)
				gdr_pkg::GDR_REQ_ST0:
					reply_reg <= '{head_of(`GDR_ID_ST0, req_ok_in, 1'b0), st0_reg}; // RULE1
				gdr_pkg::GDR_REQ_ST1:
					reply_reg <= '{head_of(`GDR_ID_ST1, req_ok_in, 1'b0), st1_reg}; // RULE2
				gdr_pkg::GDR_REQ_SET2:
					reply_reg <= '{head_of(`GDR_ID_SET2, set_ack, 1'b0),
						set_ack ? req_data_in : cfg_reg}; // RULE9
				gdr_pkg::GDR_REQ_GET2:
					reply_reg <= '{head_of(`GDR_ID_GET2, req_ok_in, 1'b0), cfg_reg}; // RULE10
			endcase
		end else if (start_unsol) begin
			if (pend0_reg)
				reply_reg <= '{head_of(`GDR_ID_ST0, 1'b0, 1'b1), st0_reg}; // RULE1
			else
				reply_reg <= '{head_of(`GDR_ID_ST1, 1'b0, 1'b1), st1_reg}; // RULE2
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			byte_reg <= 8'h00;
		else if (head_done)
			byte_reg <= reply_reg.data; // RULE13
		else if (take_req || start_unsol)
			byte_reg <= 8'h00;
	end

	// header comes straight from the snapshot, data from the byte register
	assign tx_valid_out           = (state_reg != gdr_pkg::GDR_IDLE);
	assign tx_last_out            = (state_reg == gdr_pkg::GDR_DATA);
	assign tx_byte_out            = tx_last_out ? byte_reg : reply_reg.head; // RULE14
	assign fault_status_low_out   = st0_reg;
	assign fault_status_high_out  = st1_reg;
	assign gate_timing_config_out = cfg_reg;
	assign dead_time_cycles_out   = dead_reg;
	assign blank_time_cycles_out  = blank_reg;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_take(gdr_pkg::gdr_req_t k, logic ok);
		take_req && req_kind_in == k && req_ok_in == ok;
	endsequence

	sequence s_head_sent;
		tx_valid_out && !tx_last_out && tx_ready_in;
	endsequence

	// header shown and data snapshot taken from the config at the taking edge
	sequence s_get_snapshot;
		tx_valid_out && !tx_last_out && tx_byte_out == 8'h48
			&& reply_reg.data == $past(gate_timing_config_out);
	endsequence

	a_st0_header: assert property (s_take(gdr_pkg::GDR_REQ_ST0, 1'b1) |=> // RULE1
		tx_valid_out && tx_byte_out == 8'h45)
		else $error("status low ack header wrong");

	a_st1_nack_header: assert property (s_take(gdr_pkg::GDR_REQ_ST1, 1'b0) |=> // RULE2
		tx_byte_out == 8'h06)
		else $error("status high nack header wrong");

	a_temp_flags: assert property (fault_status_low_out[1:0] == // RULE3
		{$past(fault_in.tj_over, 3), $past(fault_in.tj_warn, 3)} || $past(!rst_b_in, 3))
		else $error("temperature flags do not follow pins");

	a_supply_flags: assert property (##3 fault_status_low_out[4:2] == // RULE4
		$past({fault_in.vdd_ov, fault_in.vddh_ov, fault_in.vdd_uv}, 3))
		else $error("supply flags do not follow pins");

	a_buck_flags: assert property (##3 fault_status_low_out[7:5] == // RULE5
		$past({fault_in.buck_bor, fault_in.buck_uvw, fault_in.buck_oc}, 3))
		else $error("regulator flags do not follow pins");

	a_fet_flags: assert property (##3 fault_status_high_out[3:2] == // RULE6
		$past({fault_in.ext_oc, fault_in.ext_undervoltage_lockout}, 3))
		else $error("transistor flags do not follow pins");

	a_cfg_lost_hold: assert property (fault_status_high_out[4] && !set_ack // RULE7
		|=> fault_status_high_out[4])
		else $error("config lost flag dropped without config write");

	a_rsvd_zero: assert property ((fault_status_high_out // RULE8
		& `GDR_S1_RSVD_MASK) == 8'h00)
		else $error("reserved status bits set");

	a_set_ack: assert property (set_ack && !bor_s2_reg |=> // RULE9
		tx_byte_out == 8'h47 && gate_timing_config_out == $past(req_data_in))
		else $error("set config reply or store wrong");

	a_get_reply: assert property (s_take(gdr_pkg::GDR_REQ_GET2, 1'b1) |=> // RULE10
		s_get_snapshot)
		else $error("get config reply wrong");

	a_dead_count: assert property (##1 dead_time_cycles_out == // RULE11
		ns_to_cycles(2000 - 250 * int'($past(gate_timing_config_out[4:2]))))
		else $error("dead time count wrong");

	a_blank_count: assert property ($past(gate_timing_config_out[1:0]) == 2'b11 // RULE12
		|-> blank_time_cycles_out == 8'h05)
		else $error("blanking count wrong");

	a_data_follows: assert property (s_head_sent |=> // RULE13
		tx_valid_out && tx_last_out && tx_byte_out == $past(reply_reg.data))
		else $error("data byte does not follow header");

	a_header_shape: assert property (tx_valid_out && !tx_last_out |-> // RULE14
		!(tx_byte_out[7] && tx_byte_out[6]) && tx_byte_out[5:0] inside {[6'h05:6'h08]})
		else $error("header byte malformed");

endmodule : gdr_reply

// file: sim/gdr_host_model.sv
`timescale 1ns/1ns
module gdr_host_model (
	input  wire logic       core_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       stall_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_byte_in,
	input  wire logic       tx_last_in,
	output logic            tx_ready_out,
	output logic [7:0]      head_out,
	output logic [7:0]      data_out,
	output logic [7:0]      pairs_out,
	output logic            order_err_out
);
	logic got_head;

	// stalls every other cycle when asked
	always @(negedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			tx_ready_out <= 1'b0;
		else
			tx_ready_out <= stall_in ? ~tx_ready_out : 1'b1;
	end

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			got_head      <= 1'b0;
			head_out      <= 8'h00;
			data_out      <= 8'h00;
			pairs_out     <= 8'h00;
			order_err_out <= 1'b0;
		end else if (tx_valid_in && tx_ready_out) begin
			if (!tx_last_in) begin
				head_out <= tx_byte_in;
				got_head <= 1'b1;
				if (got_head) order_err_out <= 1'b1;
			end else begin
				data_out  <= tx_byte_in;
				got_head  <= 1'b0;
				pairs_out <= pairs_out + 8'h01;
				if (!got_head) order_err_out <= 1'b1;
			end
		end
	end
endmodule : gdr_host_model

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic                core_clk_in = 1'b0;
	logic                rst_b_in    = 1'b0;
	gdr_pkg::gdr_fault_t fault       = '0;
	gdr_pkg::gdr_req_t   kind        = gdr_pkg::GDR_REQ_ST0;
	logic                brown = 1'b0, valid = 1'b0, ok = 1'b0, stall = 1'b0;
	logic [7:0]          wdata = 8'h00;
	logic                ready, txv, txr, txl, oerr;
	logic [7:0]          txb, st_lo, st_hi, cfg, dead, blank, hd, dt, pairs, head, data;
	int                  mismatches = 0;
	int                  tests_run = 0;

	always #50 core_clk_in = ~core_clk_in;

	gdr_reply #(.CLK_PERIOD_NS(100)) i_gdr_reply (.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in), .fault_in(fault), .brownout_in(brown), .req_valid_in(valid),
		.req_ready_out(ready), .req_kind_in(kind), .req_ok_in(ok), .req_data_in(wdata),
		.tx_valid_out(txv), .tx_ready_in(txr), .tx_byte_out(txb), .tx_last_out(txl),
		.fault_status_low_out(st_lo), .fault_status_high_out(st_hi),
		.gate_timing_config_out(cfg), .dead_time_cycles_out(dead),
		.blank_time_cycles_out(blank));

	gdr_host_model i_gdr_host_model (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.stall_in(stall), .tx_valid_in(txv), .tx_byte_in(txb), .tx_last_in(txl),
		.tx_ready_out(txr), .head_out(hd), .data_out(dt), .pairs_out(pairs),
		.order_err_out(oerr));

	task finish_test;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task timeout;
		mismatches++;
		$display("Error at %0t: timeout got %h expected %h", $time, pairs, 8'hFF);
		finish_test();
	endtask : timeout

	task wait_pair;
		logic [7:0] n;
		n = pairs;
		for (int k = 0; k < 80; k++) begin
			@(negedge core_clk_in);
			if (pairs !== n) begin
				head = hd;
				data = dt;
				chk({7'h00, oerr}, 8'h00);
				return;
			end
		end
		timeout();
	endtask : wait_pair

	task request(input gdr_pkg::gdr_req_t k, input logic a, input logic [7:0] d);
		@(negedge core_clk_in);
		valid = 1'b1;
		kind  = k;
		ok    = a;
		wdata = d;
		for (int i = 0; i < 40; i++) begin
			if (ready === 1'b1) begin
				@(negedge core_clk_in);
				valid = 1'b0;
				wait_pair();
				return;
			end
			@(negedge core_clk_in);
		end
		timeout();
	endtask : request

	task t_reset;
		chk(st_lo, 8'h01);
		chk(st_hi, 8'h10);
		chk(cfg, 8'h00);
		chk(dead, 8'h14);
		chk(blank, 8'h28);
	endtask : t_reset

	task t_status;
		request(gdr_pkg::GDR_REQ_ST0, 1'b1, 8'h00);
		chk(head, 8'h45);
		chk(data, 8'h00);
		request(gdr_pkg::GDR_REQ_ST0, 1'b0, 8'h00);
		chk(head, 8'h05);
		request(gdr_pkg::GDR_REQ_ST1, 1'b1, 8'h00);
		chk(head, 8'h46);
		chk(data, 8'h10);
		request(gdr_pkg::GDR_REQ_ST1, 1'b0, 8'h00);
		chk(head, 8'h06);
	endtask : t_status

	task t_config;
		logic [7:0] c;
		for (int i = 0; i < 8; i++) begin
			stall = i[0];
			c = {3'b000, i[2:0], i[1:0]};
			request(gdr_pkg::GDR_REQ_SET2, 1'b1, c);
			chk(head, 8'h47);
			chk(data, c);
			repeat (2) @(negedge core_clk_in);
			chk(cfg, c);
			chk(dead, 8'((2000 - 250 * i + 99) / 100));
			chk(blank, 8'((4000 >> i[1:0]) / 100));
		end
		stall = 1'b0;
		chk(st_hi, 8'h00);
		request(gdr_pkg::GDR_REQ_GET2, 1'b1, 8'h00);
		chk(head, 8'h48);
		chk(data, c);
		request(gdr_pkg::GDR_REQ_SET2, 1'b1, 8'hE0);
		chk(head, 8'h07);
		chk(data, c);
		request(gdr_pkg::GDR_REQ_SET2, 1'b0, 8'h01);
		chk(head, 8'h07);
		chk(cfg, c);
		request(gdr_pkg::GDR_REQ_GET2, 1'b0, 8'h00);
		chk(head, 8'h08);
	endtask : t_config

	task t_faults;
		logic [7:0] hi_map [3];
		hi_map = '{8'h04, 8'h08, 8'h20};
		for (int i = 0; i < 11; i++) begin
			stall = i[0];
			fault = gdr_pkg::gdr_fault_t'(11'h001 << i);
			wait_pair();
			if (i < 8) begin
				chk(head, 8'h85);
				chk(data, 8'h01 << i);
			end else begin
				chk(head, 8'h86);
				chk(data, hi_map[i - 8]);
			end
			fault = '0;
			repeat (6) @(negedge core_clk_in);
		end
		stall = 1'b0;
	endtask : t_faults

	task t_brownout;
		@(negedge core_clk_in);
		brown = 1'b1;
		repeat (4) @(negedge core_clk_in);
		brown = 1'b0;
		wait_pair();
		chk(head, 8'h86);
		chk(data, 8'h10);
		chk(cfg, 8'h00);
		chk(dead, 8'h14);
	endtask : t_brownout

	initial begin
		repeat (5) @(negedge core_clk_in);
		t_reset();
		@(negedge core_clk_in);
		rst_b_in = 1'b1;
		repeat (6) @(negedge core_clk_in);
		chk(st_lo, 8'h00);
		t_status();
		t_config();
		t_faults();
		t_brownout();
		finish_test();
	end
endmodule : testbench
